// ==== include/pcc_consts.svh ====
// Offsets, field positions, reset values and timing counts of the clock controller
`ifndef PCC_CONSTS_SVH
`define PCC_CONSTS_SVH

`define PCC_ADDR_W            4
`define PCC_DATA_W            16
`define PCC_OFF_PLL_CTRL      4'h0
`define PCC_OFF_SYS_CLK_CTRL  4'h1
`define PCC_OFF_RESET_STATUS  4'h2
`define PCC_OFF_PIT_LOAD      4'h3
`define PCC_OFF_PIT_COUNT     4'h4
`define PCC_OFF_IRQ_STATUS    4'h5
`define PCC_OFF_IRQ_MASK      4'h6

`define PCC_MF_LSB            0
`define PCC_MF_MSB            3
`define PCC_STICKY_LOSS_BIT   8
`define PCC_EXT_BUS_DIV_FIELD_LSB          0
`define PCC_EXT_BUS_DIV_FIELD_MSB          1
`define PCC_RTC_DIV_BIT       4
`define PCC_PIT_DIV_BIT       5
`define PCC_LOSS_RESET_BIT    0
`define PCC_IRQ_PIT_BIT       0
`define PCC_IRQ_LOSS_BIT      1

`define PCC_EXT_BUS_DIV_FIELD_ZERO         2'h0
`define PCC_EXT_BUS_DIV_FIELD_ONE          2'h1
`define PCC_RST_MF            4'h4
`define PCC_RST_SYS_CLK_CTRL  16'h0031
`define PCC_RST_PIT_LOAD      16'hFFFF

`define PCC_DIV_SHORT         9'h003
`define PCC_DIV_LONG          9'h1FF

`define PCC_CLK_NS            100
`define PCC_SETTLE_NS         2000
`define PCC_SETTLE_CYC        ((`PCC_SETTLE_NS + `PCC_CLK_NS - 1) / `PCC_CLK_NS)
`define PCC_LONG_XFER_CYC     16
`define PCC_CNT_W             8

`endif

// ==== include/pcc_pkg.sv ====
// Types for the two ends of the clock controller link: freeze states for the controller, host states for the host
package pcc_pkg;
    typedef enum {PCC_RUN, PCC_PEND, PCC_FROZEN} pcc_freeze_t;
    typedef enum {PCC_H_IDLE, PCC_H_PLL, PCC_H_DELAY, PCC_H_EB0, PCC_H_EB1,
                  PCC_H_REPLL} pcc_host_t;
endpackage : pcc_pkg

// ==== include/pcc_link_if.sv ====
// Link between the core-side host and the clock controller
`timescale 1ns/1ns
`include "pcc_consts.svh"
interface pcc_link_if;
    logic [`PCC_ADDR_W-1:0] regAddr;
    logic [`PCC_DATA_W-1:0] regWdata;
    logic                   regWr;
    logic                   regRd;
    logic [`PCC_DATA_W-1:0] regRdata;
    logic                   busReq;
    logic                   busGrant;
    logic                   clkFrozen;
    logic                   irq;

    modport dev  (input regAddr, regWdata, regWr, regRd, busReq,
                  output regRdata, busGrant, clkFrozen, irq);
    modport host (output regAddr, regWdata, regWr, regRd, busReq,
                  input regRdata, busGrant, clkFrozen, irq);
endinterface : pcc_link_if

// ==== logic/pcc_clock_ctrl.sv ====
// Clock controller end: PLL control, clock freeze, lock status, PIT prescaler
// Operation
// - Output clock stays in phase with reference
// - PLL change then restore realigns phase
// - Bus divider 00 then 01, rewrite realigns
// - Multiplier change freezes clocks while settling
// - Never freeze during a visible bus access
// - Loss reset flag only for unintended loss
// - Software reads sticky lock-loss bit instead
// - No extra clock grant after PLL write
// - Software delay after PLL write, aligned
// - PIT is 16-bit counter on prescaled tick
// - Timer clocks predivided by 4 or 512
// - Predivide field 1 selects 512
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ns
`include "pcc_consts.svh"
module pcc_clock_ctrl
    import pcc_pkg::*;
(
    input  wire logic  sys_clk,
    input  wire logic  rst,
    pcc_link_if.dev    link,
    input  wire logic  extRefClock,
    input  wire logic  extBusBusy,
    input  wire logic  pllUnlock,
    output logic       sysClockOut,
    output logic       rtcTick,
    output logic       pitTick
);
    logic [3:0]               multFactor_ff;
    logic                     stickyLoss_ff;
    logic [`PCC_DATA_W-1:0]   sysClkCtrl_ff;
    logic                     lossResetFlag_ff;
    logic [`PCC_DATA_W-1:0]   pitLoad_ff;
    logic [`PCC_DATA_W-1:0]   pitCount_ff;
    logic [1:0]               irqStatus_ff;
    logic [1:0]               irqMask_ff;
    logic [`PCC_DATA_W-1:0]   regRdata_ff;
    logic                     busGrant_ff;
    logic                     clkFrozen_ff;
    logic                     irq_ff;
    logic                     sysClockOut_ff;
    logic                     rtcTick_ff;
    logic                     pitTick_ff;
    logic                     ebdfZeroSeen_ff;
    logic                     realignArmed_ff;
    logic [`PCC_CNT_W-1:0]    settleCnt_ff;
    logic [8:0]               rtcDiv_ff;
    logic [8:0]               pitDiv_ff;
    pcc_freeze_t              freeze_ff;

    logic                     wrPll;
    logic                     wrSys;
    logic                     mfChange;
    logic                     pitExpire;
    logic                     swLoss;
    logic [`PCC_DATA_W-1:0]   nxt_rdata;

    // Divider end for a select bit
    function automatic logic [8:0] pcc_div_end(input logic sel);
        pcc_div_end = sel ? `PCC_DIV_LONG : `PCC_DIV_SHORT;
    endfunction : pcc_div_end

    assign wrPll     = link.regWr && (link.regAddr == `PCC_OFF_PLL_CTRL);
    assign wrSys     = link.regWr && (link.regAddr == `PCC_OFF_SYS_CLK_CTRL);
    assign mfChange  = wrPll && (link.regWdata[`PCC_MF_MSB:`PCC_MF_LSB] != multFactor_ff);
    assign pitExpire = pitTick_ff && (pitCount_ff == 16'h0000);
    // Lock drops by design while freezing
    assign swLoss    = (freeze_ff != PCC_RUN);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            multFactor_ff <= `PCC_RST_MF;
        end else if (wrPll) begin
            multFactor_ff <= link.regWdata[`PCC_MF_MSB:`PCC_MF_LSB];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sysClkCtrl_ff <= `PCC_RST_SYS_CLK_CTRL;
        end else if (wrSys) begin
            sysClkCtrl_ff <= link.regWdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pitLoad_ff <= `PCC_RST_PIT_LOAD;
        end else if (link.regWr && (link.regAddr == `PCC_OFF_PIT_LOAD)) begin
            pitLoad_ff <= link.regWdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            freeze_ff    <= PCC_RUN;
            settleCnt_ff <= '0;
        end else begin
            case (freeze_ff)
                PCC_RUN: begin
                    if (mfChange) begin
                        freeze_ff <= PCC_PEND;
                    end
                end
                PCC_PEND: begin
                    if (!extBusBusy) begin
                        freeze_ff    <= PCC_FROZEN;
                        settleCnt_ff <= `PCC_CNT_W'(`PCC_SETTLE_CYC - 1);
                    end
                end
                PCC_FROZEN: begin
                    if (settleCnt_ff == '0) begin
                        freeze_ff <= PCC_RUN;
                    end else begin
                        settleCnt_ff <= settleCnt_ff - 1'b1;
                    end
                end
                default: begin
                    freeze_ff <= PCC_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            busGrant_ff <= 1'b0;
        end else begin
            busGrant_ff <= link.busReq && !mfChange && (freeze_ff == PCC_RUN);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clkFrozen_ff <= 1'b0;
        end else begin
            clkFrozen_ff <= (freeze_ff == PCC_FROZEN);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ebdfZeroSeen_ff <= 1'b0;
            realignArmed_ff <= 1'b0;
        end else if (wrSys) begin
            ebdfZeroSeen_ff <= (link.regWdata[`PCC_EXT_BUS_DIV_FIELD_MSB:`PCC_EXT_BUS_DIV_FIELD_LSB] == `PCC_EXT_BUS_DIV_FIELD_ZERO);
            if (ebdfZeroSeen_ff &&
                link.regWdata[`PCC_EXT_BUS_DIV_FIELD_MSB:`PCC_EXT_BUS_DIV_FIELD_LSB] == `PCC_EXT_BUS_DIV_FIELD_ONE) begin
                realignArmed_ff <= 1'b1;
            end
        end else if (wrPll) begin
            realignArmed_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sysClockOut_ff <= 1'b0;
        end else if (freeze_ff == PCC_FROZEN || (wrPll && realignArmed_ff)) begin
            sysClockOut_ff <= 1'b0;
        end else begin
            sysClockOut_ff <= extRefClock;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lossResetFlag_ff <= 1'b0;
        end else if (pllUnlock && !swLoss) begin
            lossResetFlag_ff <= 1'b1;
        end else if (link.regWr && link.regAddr == `PCC_OFF_RESET_STATUS &&
                     link.regWdata[`PCC_LOSS_RESET_BIT]) begin
            lossResetFlag_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stickyLoss_ff <= 1'b0;
        end else if (pllUnlock || mfChange) begin
            stickyLoss_ff <= 1'b1;
        end else if (wrPll && link.regWdata[`PCC_STICKY_LOSS_BIT]) begin
            stickyLoss_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rtcDiv_ff <= '0;
            rtcTick_ff <= 1'b0;
        end else if (rtcDiv_ff >= pcc_div_end(sysClkCtrl_ff[`PCC_RTC_DIV_BIT])) begin
            rtcDiv_ff <= '0;
            rtcTick_ff <= 1'b1;
        end else begin
            rtcDiv_ff <= rtcDiv_ff + 1'b1;
            rtcTick_ff <= 1'b0;
        end
    end

    // Counts stop while frozen, as the clocks do
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pitDiv_ff <= '0;
            pitTick_ff <= 1'b0;
        end else if (freeze_ff == PCC_FROZEN) begin
            pitTick_ff <= 1'b0;
        end else if (pitDiv_ff >= pcc_div_end(sysClkCtrl_ff[`PCC_PIT_DIV_BIT])) begin
            pitDiv_ff <= '0;
            pitTick_ff <= 1'b1;
        end else begin
            pitDiv_ff <= pitDiv_ff + 1'b1;
            pitTick_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pitCount_ff <= `PCC_RST_PIT_LOAD;
        end else if (link.regWr && (link.regAddr == `PCC_OFF_PIT_LOAD)) begin
            pitCount_ff <= link.regWdata;
        end else if (pitExpire) begin
            pitCount_ff <= pitLoad_ff;
        end else if (pitTick_ff) begin
            pitCount_ff <= pitCount_ff - 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irqStatus_ff <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == `PCC_IRQ_PIT_BIT && pitExpire) ||
                    (i == `PCC_IRQ_LOSS_BIT && pllUnlock && !swLoss)) begin
                    irqStatus_ff[i] <= 1'b1;
                end else if (link.regWr && link.regAddr == `PCC_OFF_IRQ_STATUS &&
                             link.regWdata[i]) begin
                    irqStatus_ff[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irqMask_ff <= 2'h0;
        end else if (link.regWr && (link.regAddr == `PCC_OFF_IRQ_MASK)) begin
            irqMask_ff <= link.regWdata[1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irqStatus_ff & irqMask_ff);
        end
    end

    always_comb begin
        nxt_rdata = '0;
        case (link.regAddr)
            `PCC_OFF_PLL_CTRL: begin
                nxt_rdata[`PCC_MF_MSB:`PCC_MF_LSB] = multFactor_ff;
                nxt_rdata[`PCC_STICKY_LOSS_BIT]     = stickyLoss_ff;
            end
            `PCC_OFF_SYS_CLK_CTRL: nxt_rdata = sysClkCtrl_ff;
            `PCC_OFF_RESET_STATUS: nxt_rdata[`PCC_LOSS_RESET_BIT] = lossResetFlag_ff;
            `PCC_OFF_PIT_LOAD:     nxt_rdata = pitLoad_ff;
            `PCC_OFF_PIT_COUNT:    nxt_rdata = pitCount_ff;
            `PCC_OFF_IRQ_STATUS:   nxt_rdata[1:0] = irqStatus_ff;
            `PCC_OFF_IRQ_MASK:     nxt_rdata[1:0] = irqMask_ff;
            default:               nxt_rdata = '0;
        endcase
    end

    // Read data stands one cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            regRdata_ff <= '0;
        end else begin
            regRdata_ff <= link.regRd ? nxt_rdata : '0;
        end
    end

    assign link.regRdata  = regRdata_ff;
    assign link.busGrant  = busGrant_ff;
    assign link.clkFrozen = clkFrozen_ff;
    assign link.irq       = irq_ff;
    assign sysClockOut    = sysClockOut_ff;
    assign rtcTick        = rtcTick_ff;
    assign pitTick        = pitTick_ff;
endmodule : pcc_clock_ctrl

// ==== logic/pcc_core_host.sv ====
// Core-side end: register access, safe PLL write sequence, bus requests
`timescale 1ns/1ns
`include "pcc_consts.svh"
module pcc_core_host
    import pcc_pkg::*;
(
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    pcc_link_if.host                    link,
    input  wire logic [`PCC_ADDR_W-1:0] cmdAddr,
    input  wire logic [`PCC_DATA_W-1:0] cmdWdata,
    input  wire logic                   cmdWr,
    input  wire logic                   cmdRd,
    input  wire logic                   cmdRealign,
    input  wire logic                   coreBusReq,
    output logic [`PCC_DATA_W-1:0]      cmdRdata,
    output logic                        cmdBusy,
    output logic                        coreBusGrant,
    output logic                        irq
);
    pcc_host_t              state_ff;
    logic [`PCC_ADDR_W-1:0] addr_ff;
    logic [`PCC_DATA_W-1:0] wdata_ff;
    logic                   wr_ff;
    logic                   rd_ff;
    logic                   busReq_ff;
    logic [`PCC_DATA_W-1:0] pllVal_ff;
    logic [`PCC_DATA_W-1:0] cmdRdata_ff;
    logic                   cmdBusy_ff;
    logic                   grant_ff;
    logic                   irq_ff;
    logic [`PCC_CNT_W-1:0]  delay_ff;
    logic [`PCC_DATA_W-1:0] sysVal;
    logic [`PCC_DATA_W-1:0] sysShadow_ff;

    assign sysVal = cmdWdata | (`PCC_DATA_W'(1) << `PCC_PIT_DIV_BIT);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_ff  <= PCC_H_IDLE;
            addr_ff   <= '0;
            wdata_ff  <= '0;
            wr_ff     <= 1'b0;
            rd_ff     <= 1'b0;
            pllVal_ff <= '0;
            delay_ff  <= '0;
        end else begin
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            case (state_ff)
                PCC_H_IDLE: begin
                    if (cmdRealign) begin
                        state_ff <= PCC_H_EB0;
                        addr_ff  <= `PCC_OFF_SYS_CLK_CTRL;
                        wdata_ff <= sysShadow_ff & ~`PCC_DATA_W'(3);
                        wr_ff    <= 1'b1;
                        pllVal_ff <= cmdWdata;
                    end else if (cmdWr && cmdAddr == `PCC_OFF_PLL_CTRL) begin
                        state_ff  <= PCC_H_DELAY;
                        addr_ff   <= cmdAddr;
                        wdata_ff  <= cmdWdata;
                        wr_ff     <= 1'b1;
                        delay_ff  <= `PCC_CNT_W'(`PCC_LONG_XFER_CYC);
                    end else if (cmdWr) begin
                        addr_ff  <= cmdAddr;
                        wdata_ff <= (cmdAddr == `PCC_OFF_SYS_CLK_CTRL) ? sysVal : cmdWdata;
                        wr_ff    <= 1'b1;
                    end else if (cmdRd) begin
                        addr_ff <= cmdAddr;
                        rd_ff   <= 1'b1;
                    end
                end
                PCC_H_EB0: begin
                    state_ff <= PCC_H_EB1;
                    wdata_ff <= (wdata_ff & ~`PCC_DATA_W'(3)) | `PCC_DATA_W'(`PCC_EXT_BUS_DIV_FIELD_ONE);
                    wr_ff    <= 1'b1;
                end
                PCC_H_EB1: begin
                    state_ff <= PCC_H_DELAY;
                    addr_ff  <= `PCC_OFF_PLL_CTRL;
                    wdata_ff <= pllVal_ff;
                    wr_ff    <= 1'b1;
                    delay_ff <= `PCC_CNT_W'(`PCC_LONG_XFER_CYC);
                end
                PCC_H_DELAY: begin
                    if (delay_ff == '0 && !link.clkFrozen) begin
                        state_ff <= PCC_H_IDLE;
                    end else if (delay_ff != '0) begin
                        delay_ff <= delay_ff - 1'b1;
                    end
                end
                default: begin
                    state_ff <= PCC_H_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            busReq_ff <= 1'b0;
        end else begin
            busReq_ff <= coreBusReq && (state_ff == PCC_H_IDLE) && !cmdRealign &&
                         !(cmdWr && cmdAddr == `PCC_OFF_PLL_CTRL);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cmdBusy_ff <= 1'b0;
            grant_ff   <= 1'b0;
            irq_ff     <= 1'b0;
            cmdRdata_ff <= '0;
            sysShadow_ff <= `PCC_RST_SYS_CLK_CTRL;
        end else begin
            if (wr_ff && addr_ff == `PCC_OFF_SYS_CLK_CTRL) sysShadow_ff <= wdata_ff;
            cmdBusy_ff <= (state_ff != PCC_H_IDLE) || cmdRealign ||
                          (cmdWr && cmdAddr == `PCC_OFF_PLL_CTRL);
            grant_ff   <= link.busGrant;
            irq_ff     <= link.irq;
            cmdRdata_ff <= link.regRdata;
        end
    end

    assign link.regAddr  = addr_ff;
    assign link.regWdata = wdata_ff;
    assign link.regWr    = wr_ff;
    assign link.regRd    = rd_ff;
    assign link.busReq   = busReq_ff;
    assign cmdRdata      = cmdRdata_ff;
    assign cmdBusy       = cmdBusy_ff;
    assign coreBusGrant  = grant_ff;
    assign irq           = irq_ff;
endmodule : pcc_core_host

// ==== verif/pcc_link_properties.sv ====
// Concurrent checks on the link between host and clock controller
`timescale 1ns/1ns
`include "pcc_consts.svh"
module pcc_link_properties (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic [3:0]  regAddr,
    input wire logic [15:0] regWdata,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [15:0] regRdata,
    input wire logic        busReq,
    input wire logic        busGrant,
    input wire logic        clkFrozen,
    input wire logic        irq
);
    logic [3:0] mfShadow_ff;
    logic [7:0] frozenCnt_ff;
    logic       pllWr, pllRd, sysRd, mfChg, eb0, eb1;
    assign pllWr = regWr && regAddr == `PCC_OFF_PLL_CTRL;
    assign pllRd = regRd && regAddr == `PCC_OFF_PLL_CTRL;
    assign sysRd = regRd && regAddr == `PCC_OFF_SYS_CLK_CTRL;
    assign mfChg = pllWr && regWdata[3:0] != mfShadow_ff;
    assign eb0 = regWr && regAddr == `PCC_OFF_SYS_CLK_CTRL && regWdata[1:0] == `PCC_EXT_BUS_DIV_FIELD_ZERO;
    assign eb1 = regWr && regAddr == `PCC_OFF_SYS_CLK_CTRL && regWdata[1:0] == `PCC_EXT_BUS_DIV_FIELD_ONE;
    // Multiplier mirror tells a rewrite from a change
    always_ff @(posedge sys_clk) begin
        if (rst) mfShadow_ff <= `PCC_RST_MF;
        else if (pllWr) mfShadow_ff <= regWdata[3:0];
    end
    always_ff @(posedge sys_clk) begin
        if (rst || !clkFrozen) frozenCnt_ff <= 8'h00;
        else frozenCnt_ff <= frozenCnt_ff + 8'h01;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_mf_grant_block: assert property (mfChg |=> !busGrant)
        else $error("grant given right after a multiplier change");
    a_mf_freeze: assert property (mfChg |-> ##[2:40] clkFrozen)
        else $error("multiplier change did not freeze the clocks");
    a_freeze_len: assert property ($fell(clkFrozen) |-> frozenCnt_ff == `PCC_SETTLE_CYC)
        else $error("freeze length differs from settle time");
    a_frozen_no_grant: assert property (clkFrozen |-> !busGrant)
        else $error("grant while clocks frozen");
    a_grant_cause: assert property (busGrant |-> $past(busReq))
        else $error("grant without a request");
    a_pll_delay: assert property (pllWr |=> !busReq [*8] ##1 !busReq [*8])
        else $error("bus request inside the post write delay");
    a_realign_order: assert property (eb0 |=> eb1 ##1 pllWr)
        else $error("realign writes out of order");
    a_div_long: assert property (sysRd |=> regRdata[`PCC_PIT_DIV_BIT])
        else $error("timer predivide not at long setting");
    a_mf_readback: assert property (pllRd |=> regRdata[3:0] == $past(mfShadow_ff))
        else $error("multiplier read back wrong");
    c_freeze: cover property ($rose(clkFrozen));
    c_irq: cover property ($rose(irq));
    c_grant: cover property (busReq && busGrant);
    c_realign: cover property (eb0 ##1 eb1);
endmodule : pcc_link_properties

// ==== verif/tb_pll_clock_ctrl_pit_prescale.sv ====
// Testbench joining host and clock controller across the link
`timescale 1ns/1ns
`include "pcc_consts.svh"
module tb_pll_clock_ctrl_pit_prescale;
    typedef struct packed {
        logic [3:0]  a;
        logic        wr;
        logic [15:0] d;
        logic [15:0] e;
    } pcc_row_t;
    logic        sys_clk, rst, cmdWr, cmdRd, cmdRealign, coreBusReq;
    logic        extBusBusy, pllUnlock, extRefClock, clkFrozen;
    logic        cmdBusy, coreBusGrant, irq, sysClockOut, rtcTick, pitTick;
    logic [3:0]  cmdAddr;
    logic [15:0] cmdWdata, cmdRdata;
    logic [1:0]  refCnt_ff;
    int          n_fail, compares, cycles, n, i;
    pcc_row_t    rows [10] = '{
        '{`PCC_OFF_PLL_CTRL, 1'h0, 16'h0000, 16'h0004},
        '{`PCC_OFF_SYS_CLK_CTRL, 1'h0, 16'h0000, 16'h0031},
        '{`PCC_OFF_PIT_LOAD, 1'h0, 16'h0000, 16'hFFFF},
        '{`PCC_OFF_RESET_STATUS, 1'h0, 16'h0000, 16'h0000},
        '{`PCC_OFF_IRQ_STATUS, 1'h0, 16'h0000, 16'h0000},
        '{`PCC_OFF_IRQ_MASK, 1'h0, 16'h0000, 16'h0000},
        '{`PCC_OFF_SYS_CLK_CTRL, 1'h1, 16'h0001, 16'h0021},
        '{`PCC_OFF_PIT_LOAD, 1'h1, 16'h1234, 16'h1234},
        '{4'h7, 1'h1, 16'hBEEF, 16'h0000},
        '{`PCC_OFF_IRQ_MASK, 1'h1, 16'h0003, 16'h0003}};
    pcc_link_if pcc_link_if_inst ();
    pcc_clock_ctrl pcc_clock_ctrl_inst (.sys_clk(sys_clk), .rst(rst), .link(pcc_link_if_inst),
        .extRefClock(extRefClock), .extBusBusy(extBusBusy), .pllUnlock(pllUnlock),
        .sysClockOut(sysClockOut), .rtcTick(rtcTick), .pitTick(pitTick));
    pcc_core_host pcc_core_host_inst (.sys_clk(sys_clk), .rst(rst), .link(pcc_link_if_inst),
        .cmdAddr(cmdAddr), .cmdWdata(cmdWdata), .cmdWr(cmdWr), .cmdRd(cmdRd),
        .cmdRealign(cmdRealign), .coreBusReq(coreBusReq), .cmdRdata(cmdRdata),
        .cmdBusy(cmdBusy), .coreBusGrant(coreBusGrant), .irq(irq));
    pcc_link_properties pcc_link_properties_inst (.sys_clk(sys_clk), .rst(rst),
        .regAddr(pcc_link_if_inst.regAddr), .regWdata(pcc_link_if_inst.regWdata),
        .regWr(pcc_link_if_inst.regWr), .regRd(pcc_link_if_inst.regRd),
        .regRdata(pcc_link_if_inst.regRdata), .busReq(pcc_link_if_inst.busReq),
        .busGrant(pcc_link_if_inst.busGrant), .clkFrozen(pcc_link_if_inst.clkFrozen),
        .irq(pcc_link_if_inst.irq));
    assign clkFrozen = pcc_link_if_inst.clkFrozen;
    assign extRefClock = refCnt_ff[1];
    always #50 sys_clk = ~sys_clk;
    // Quarter-rate reference shows phase slips
    always @(posedge sys_clk) refCnt_ff <= refCnt_ff + 2'h1;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            final_report;
        end
    end
    task automatic final_report;
        if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Busy is registered; look after the edge
    task automatic waitIdle;
        int k;
        #1;
        for (k = 0; k < 100 && (cmdBusy !== 1'h0 || clkFrozen !== 1'h0); k++)
            @(posedge sys_clk) #1;
    endtask : waitIdle
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        waitIdle;
        @(posedge sys_clk);
        cmdAddr <= a;
        cmdWdata <= d;
        cmdWr <= 1'h1;
        @(posedge sys_clk);
        cmdWr <= 1'h0;
    endtask : wr
    task automatic expRd(input string what, input logic [3:0] a, input logic [15:0] m,
                         input logic [15:0] e);
        waitIdle;
        @(posedge sys_clk);
        cmdAddr <= a;
        cmdRd <= 1'h1;
        @(posedge sys_clk);
        cmdRd <= 1'h0;
        repeat (2) @(posedge sys_clk);
        #1 check(what, cmdRdata & m, e);
    endtask : expRd
    task automatic tickGap(input logic sel, output int g);
        for (g = 0; g < 1200 && (sel ? pitTick : rtcTick) !== 1'h1; g++) @(posedge sys_clk) #1;
        for (g = 0; g == 0 || (g < 1200 && (sel ? pitTick : rtcTick) !== 1'h1); g++)
            @(posedge sys_clk) #1;
    endtask : tickGap
    task automatic phaseCheck;
        logic prev;
        int   k;
        @(posedge sys_clk) #1;
        prev = extRefClock;
        for (k = 0; k < 12; k++) begin
            @(posedge sys_clk) #1;
            check("phase", {15'h0000, sysClockOut}, {15'h0000, prev});
            prev = extRefClock;
        end
    endtask : phaseCheck
    task automatic hardReset;
        rst <= 1'h1;
        repeat (8) @(posedge sys_clk);
        rst <= 1'h0;
    endtask : hardReset
    initial begin
        sys_clk = 1'h0;
        rst = 1'h1;
        {cmdWr, cmdRd, cmdRealign, coreBusReq, extBusBusy, pllUnlock} = 6'h00;
        cmdAddr = 4'h0;
        cmdWdata = 16'h0000;
        refCnt_ff = 2'h0;
        @(posedge sys_clk);
        hardReset;
        repeat (4) @(posedge sys_clk);
        phaseCheck;
        foreach (rows[r]) begin
            if (rows[r].wr) wr(rows[r].a, rows[r].d);
            expRd($sformatf("row%0d", r), rows[r].a, 16'hFFFF, rows[r].e);
        end
        wr(`PCC_OFF_PIT_LOAD, 16'h0002);
        tickGap(1'h1, n);
        check("pitGap", n[15:0], 16'h0200);
        tickGap(1'h0, n);
        check("rtcGap", n[15:0], 16'h0004);
        for (i = 0; i < 2000 && irq !== 1'h1; i++) @(posedge sys_clk) #1;
        check("pitIrq", {15'h0000, irq}, 16'h0001);
        expRd("pitStatus", `PCC_OFF_IRQ_STATUS, 16'h0001, 16'h0001);
        wr(`PCC_OFF_IRQ_MASK, 16'h0000);
        expRd("maskOff", `PCC_OFF_IRQ_MASK, 16'hFFFF, 16'h0000);
        check("irqMasked", {15'h0000, irq}, 16'h0000);
        wr(`PCC_OFF_IRQ_STATUS, 16'h0001);
        wr(`PCC_OFF_IRQ_MASK, 16'h0003);
        expRd("pitCleared", `PCC_OFF_IRQ_STATUS, 16'h0001, 16'h0000);
        // Multiplier change during an external access
        @(posedge sys_clk);
        extBusBusy <= 1'h1;
        coreBusReq <= 1'h1;
        wr(`PCC_OFF_PLL_CTRL, 16'h0005);
        repeat (10) @(posedge sys_clk);
        #1 check("busyNoFreeze", {15'h0000, clkFrozen}, 16'h0000);
        @(posedge sys_clk);
        extBusBusy <= 1'h0;
        for (i = 0; i < 10 && clkFrozen !== 1'h1; i++) @(posedge sys_clk) #1;
        check("frozen", {15'h0000, clkFrozen}, 16'h0001);
        check("clkStopped", {15'h0000, sysClockOut}, 16'h0000);
        check("noGrantFrozen", {15'h0000, coreBusGrant}, 16'h0000);
        @(posedge sys_clk);
        pllUnlock <= 1'h1;
        @(posedge sys_clk);
        pllUnlock <= 1'h0;
        expRd("softLoss", `PCC_OFF_RESET_STATUS, 16'hFFFF, 16'h0000);
        expRd("stickyLoss", `PCC_OFF_PLL_CTRL, 16'h010F, 16'h0105);
        check("grantAfter", {15'h0000, coreBusGrant}, 16'h0001);
        @(posedge sys_clk);
        coreBusReq <= 1'h0;
        pllUnlock <= 1'h1;
        @(posedge sys_clk);
        pllUnlock <= 1'h0;
        expRd("hardLoss", `PCC_OFF_RESET_STATUS, 16'h0001, 16'h0001);
        expRd("lossIrq", `PCC_OFF_IRQ_STATUS, 16'h0002, 16'h0002);
        @(posedge sys_clk);
        cmdWdata <= 16'h0004;
        cmdRealign <= 1'h1;
        @(posedge sys_clk);
        cmdRealign <= 1'h0;
        expRd("realignMf", `PCC_OFF_PLL_CTRL, 16'h000F, 16'h0004);
        expRd("realignDiv", `PCC_OFF_SYS_CLK_CTRL, 16'h00FF, 16'h0021);
        phaseCheck;
        // Reset on a rising reference edge
        while (refCnt_ff !== 2'h1) @(posedge sys_clk) #1;
        @(posedge sys_clk);
        hardReset;
        repeat (4) @(posedge sys_clk);
        phaseCheck;
        expRd("resetMf", `PCC_OFF_PLL_CTRL, 16'hFFFF, 16'h0004);
        final_report;
    end
endmodule : tb_pll_clock_ctrl_pit_prescale
